/* src/arrs_pkg.sv */
/*
 Package for the ADC result register slice: offsets, reset values, field layout and sequencer states.
 Assumes a byte-wide register port with a byte address, as the control port presents it.
*/
package arrs_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] OFS_TOP_CELL_VOLT_LOW = 8'h20;
   localparam logic [7:0] OFS_THERM_RATIO_HIGH = 8'h21;
   localparam logic [7:0] OFS_THERM_RATIO_LOW = 8'h22;
   localparam logic [7:0] OFS_DIE_TEMP_HIGH = 8'h23;
   // ****************************************
   // Reset values and widths
   // ****************************************
   localparam logic [7:0] RST_RESULT_BYTE = 8'h00;
   localparam logic [15:0] RST_RESULT = 16'h0000;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
   localparam int RESULT_W = 16;
   localparam int SIGN_BIT = 15;
   // ****************************************
   // Channels
   // ****************************************
   localparam int NUM_CH = 3;
   localparam int CH_TOP_CELL = 0;
   localparam int CH_THERM = 1;
   localparam int CH_DIE_TEMP = 2;
   typedef enum logic [1:0] {
      ARRS_ST_RUN,
      ARRS_ST_DEFAULTS
   } arrs_state_e;
endpackage

/* src/arrs_if.sv */
/*
 Interface carrying result update traffic into the result holding bank.
 Assumes one clock and the synchronised reset of the top module.
*/
interface arrs_res_if;
   logic [2:0] load;
   logic [15:0] value [3];
   logic clear;
   logic [15:0] held [3];
   modport src (output load, output value, output clear, input held);
   modport bank (input load, input value, input clear, output held);
endinterface

/* src/arrs_result_bank.sv */
/*
 Holding bank for the three 16-bit conversion results.
 Assumes load strobes are one-cycle pulses and clear comes from the defaults restore path.
*/
module arrs_result_bank (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Result traffic
   arrs_res_if.bank res
);
   // ****************************************
   // Per-channel holding words
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < arrs_pkg::NUM_CH; g++) begin : g_ch
         logic [15:0] word_q;
         logic [15:0] word_d;
         // Whole word loads at once, so both bytes share one conversion
         assign word_d = res.clear ? arrs_pkg::RST_RESULT :
                         (res.load[g] ? res.value[g] : word_q);
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               word_q <= arrs_pkg::RST_RESULT;
            end else begin
               word_q <= word_d;
            end
         end
         assign res.held[g] = word_q;
      end
   endgenerate
endmodule

/* src/arrs_read_mux.sv */
/*
 Read selection of the four result bytes by register offset.
 Assumes the address is stable for the read; unmapped offsets read as zero.
*/
module arrs_read_mux (
   // Held results
   input wire logic [15:0] top_cell,
   input wire logic [15:0] therm,
   input wire logic [15:0] die_temp,
   // Address and data
   input wire logic [7:0] addr,
   output logic [7:0] data,
   output logic hit
);
   wire sel_top_lo = (addr == arrs_pkg::OFS_TOP_CELL_VOLT_LOW);
   wire sel_th_hi = (addr == arrs_pkg::OFS_THERM_RATIO_HIGH);
   wire sel_th_lo = (addr == arrs_pkg::OFS_THERM_RATIO_LOW);
   wire sel_die_hi = (addr == arrs_pkg::OFS_DIE_TEMP_HIGH);
   // Low byte bit 7 weighs 128 mV down to 1 mV at bit 0
   // High byte of the ratio: bit 9 is 50 percent, bit 8 is 25 percent
   // High byte of die temperature: bit 8 is 128 degrees
   // Bit 15 is the sign, passed through untouched in the ratio and die temperature high bytes
   assign data = sel_top_lo ? top_cell[7:0] :
                 sel_th_hi ? therm[15:8] :
                 sel_th_lo ? therm[7:0] :
                 sel_die_hi ? die_temp[15:8] : arrs_pkg::RD_UNMAPPED;
   assign hit = sel_top_lo | sel_th_hi | sel_th_lo | sel_die_hi;
endmodule

/* src/arrs_top.sv */
/*
 ADC result register slice: top-cell voltage low byte, thermistor ratio bytes and
 die temperature high byte, read-only over the device's byte register port.
 Assumes the control-port engine supplies a byte address with a read strobe, and the
 conversion engine supplies whole 16-bit two's complement results with a valid pulse.
*/

// Functional notes
// - Offset 0x20 holds top-cell voltage low byte, 128 mV down to 1 mV.
// - Balancing uses its own comparator; this result is report only.
// - Offset 0x21 holds ratio high byte; bit9 50 percent, bit8 25 percent.
// - Ratio is percent of regulator rail, 12.50 to 0.098 percent, 0 to 99.9.
// - Offset 0x23 holds die temperature high byte; bit8 is 128 degrees.
// - Die temperature spans 0 to 128 degrees Celsius.
// - Each byte pair is two's complement with bit 15 as sign.
// - Results read-only, reset zero, cleared by restore, kept on watchdog.
// - Restore bit returns defaults, resets safety timer, then self-clears.
module arrs_top (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   // Defaults restore and watchdog
   input wire logic restore_req,
   input wire logic watchdog_expired,
   output logic restore_busy,
   output logic safety_timer_rst,
   // Conversion results
   input wire logic top_cell_voltage_valid,
   input wire logic [15:0] top_cell_voltage_result,
   input wire logic thermistor_ratio_valid,
   input wire logic [15:0] thermistor_ratio_result,
   input wire logic die_temperature_valid,
   input wire logic [15:0] die_temperature_result
);
   // ****************************************
   // Reset release
   // ****************************************
   logic rst_s1_q;
   logic rst_q;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_q <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_q <= rst_s1_q;
      end
   end

   // ****************************************
   // Defaults restore sequencing
   // ****************************************
   arrs_pkg::arrs_state_e state_q;
   arrs_pkg::arrs_state_e state_d;
   // One cycle of clearing, then back to run: the request bit reads back as zero
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         arrs_pkg::ARRS_ST_RUN: begin
            if (restore_req) begin
               state_d = arrs_pkg::ARRS_ST_DEFAULTS;
            end
         end
         arrs_pkg::ARRS_ST_DEFAULTS: begin
            state_d = arrs_pkg::ARRS_ST_RUN;
         end
      endcase
   end
   always_ff @(posedge mclk or negedge rst_q) begin
      if (!rst_q) begin
         state_q <= arrs_pkg::ARRS_ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end
   wire in_defaults = (state_q == arrs_pkg::ARRS_ST_DEFAULTS);
   assign restore_busy = in_defaults;
   assign safety_timer_rst = in_defaults;

   // ****************************************
   // Result bank
   // ****************************************
   arrs_res_if res ();
   // Watchdog is deliberately not an input to clearing
   assign res.clear = in_defaults;
   // Updates during the restore cycle are dropped so defaults really show
   assign res.load = in_defaults ? 3'b000 :
                     {die_temperature_valid, thermistor_ratio_valid, top_cell_voltage_valid};
   // Ratio and die temperature pass as coded by the converter
   assign res.value[arrs_pkg::CH_TOP_CELL] = top_cell_voltage_result;
   assign res.value[arrs_pkg::CH_THERM] = thermistor_ratio_result;
   assign res.value[arrs_pkg::CH_DIE_TEMP] = die_temperature_result;
   // Top-cell value is report only; balancing has its own comparator
   arrs_result_bank u_bank (
      .clk(mclk),
      .rst_n(rst_q),
      .res(res)
   );

   // ****************************************
   // Read path
   // ****************************************
   logic [7:0] mux_data;
   logic mux_hit;
   logic [7:0] rdata_q;
   arrs_read_mux u_mux (
      .top_cell(res.held[arrs_pkg::CH_TOP_CELL]),
      .therm(res.held[arrs_pkg::CH_THERM]),
      .die_temp(res.held[arrs_pkg::CH_DIE_TEMP]),
      .addr(reg_addr),
      .data(mux_data),
      .hit(mux_hit)
   );
   // Writes are ignored: every register here is read-only
   always_ff @(posedge mclk or negedge rst_q) begin
      if (!rst_q) begin
         rdata_q <= arrs_pkg::RST_RESULT_BYTE;
      end else if (reg_rd) begin
         rdata_q <= mux_data;
      end
   end
   assign reg_rdata = rdata_q;
   assign reg_hit = mux_hit & (reg_rd | reg_wr);
endmodule

/* dv/arrs_top_chk.sv */
/* Port checker for the result register slice.
 Bound to the top module; one clock, async active-low reset. */
module arrs_top_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_hit,
   // Restore, watchdog, results
   input wire logic restore_req,
   input wire logic watchdog_expired,
   input wire logic restore_busy,
   input wire logic safety_timer_rst,
   input wire logic top_cell_voltage_valid,
   input wire logic [15:0] top_cell_voltage_result,
   input wire logic thermistor_ratio_valid,
   input wire logic die_temperature_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   wire logic quiet = !(restore_req || restore_busy || top_cell_voltage_valid ||
      thermistor_ratio_valid || die_temperature_valid);
   sequence s_restored;
      restore_busy ##1 quiet ##1 (reg_rd && quiet);
   endsequence
   sequence s_reread;
      reg_rd && quiet ##1 watchdog_expired && quiet ##1 reg_rd && reg_addr == $past(reg_addr, 2);
   endsequence
   chk_hit_decode: assert property (
      reg_hit == ((reg_rd || reg_wr) && reg_addr[7:2] == 6'h08)) else $error("bad hit");
   chk_restore_pulse: assert property (restore_req && !restore_busy |=>
      restore_busy && safety_timer_rst ##1 !restore_busy) else $error("bad restore pulse");
   chk_busy_cause: assert property (
      $rose(restore_busy) |-> $past(restore_req)) else $error("busy without request");
   chk_restore_clear: assert property (
      s_restored |=> reg_rdata == 8'h00) else $error("not cleared");
   chk_rdata_holds: assert property (
      !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
   chk_watchdog_keep: assert property (
      s_reread |=> reg_rdata == $past(reg_rdata, 2)) else $error("value lost");
   chk_top_load: assert property (
      top_cell_voltage_valid && !restore_busy ##1 reg_rd && reg_addr == 8'h20 && quiet
      |=> reg_rdata == $past(top_cell_voltage_result[7:0], 2)) else $error("bad low byte");
   chk_unmapped_zero: assert property (
      reg_rd && reg_addr[7:2] != 6'h08 |=> reg_rdata == 8'h00) else $error("unmapped read");
endmodule

/* dv/arrs_host_model.sv */
/* Host side of the byte register port: reads, writes, restore.
 Assumes requests are sampled on the rising clock edge. */
module arrs_host_model (
   // Clock
   input wire logic mclk,
   // Register port
   output logic [7:0] reg_addr,
   output logic reg_rd,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // Restore bit
   output logic restore_req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {reg_addr, reg_rd, reg_wr, reg_wdata, restore_req} = '0;
   end
   // Address inverted on release, so stale values never pass
   task automatic access(input logic [7:0] a, input logic w, output logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= !w;
      reg_wr <= w;
      reg_wdata <= ~a;
      @(posedge mclk);
      {reg_rd, reg_wr} <= 2'h0;
      reg_addr <= ~a;
      @(negedge mclk);
      d = reg_rdata;
   endtask
   task automatic restore();
      @(posedge mclk);
      restore_req <= 1'b1;
      @(posedge mclk);
      restore_req <= 1'b0;
   endtask
endmodule

/* dv/test_arrs_top.sv */
/* Testbench for the result register slice.
 Assumes the host model and the port checker beside it. */
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected at %0t: read %h want %h", $time, g, e); end end
module test_arrs_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, arst_n = 0, wd = 0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic reg_rd, reg_wr, reg_hit, restore_req, restore_busy, safety_timer_rst;
   logic [2:0] v = 3'h0;
   logic [15:0] r [3] = '{default: 16'h0000};
   int num_errors = 0, compares = 0;
   initial forever #20 mclk = ~mclk;
   // Valids are single-cycle pulses
   always @(posedge mclk) if (v != 3'h0) v <= 3'h0;
   arrs_top arrs_top_i (.mclk, .arst_n, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata,
      .reg_hit, .restore_req, .watchdog_expired(wd), .restore_busy, .safety_timer_rst,
      .top_cell_voltage_valid(v[0]), .top_cell_voltage_result(r[0]),
      .thermistor_ratio_valid(v[1]), .thermistor_ratio_result(r[1]),
      .die_temperature_valid(v[2]), .die_temperature_result(r[2]));
   arrs_host_model arrs_host_model_i (.mclk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
      .reg_rdata, .restore_req);
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      arrs_host_model_i.access(a, 1'b0, d);
      `CHK(d, e)
   endtask
   task automatic load(input int ch, input logic [15:0] x);
      @(posedge mclk);
      v[ch] <= 1'b1;
      r[ch] <= x;
   endtask
   task automatic finish_test();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      repeat (10) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      for (logic [7:0] a = 8'h20; a < 8'h25; a++) rd_chk(a, 8'h00);
      load(0, 16'hFE81);
      rd_chk(8'h20, 8'h81);
      load(1, 16'h03FF);
      rd_chk(8'h21, 8'h03);
      rd_chk(8'h22, 8'hFF);
      load(2, 16'h0100);
      rd_chk(8'h23, 8'h01);
      arrs_host_model_i.access(8'h20, 1'b1, d);
      rd_chk(8'h20, 8'h81);
      @(posedge mclk) wd <= 1'b1;
      rd_chk(8'h21, 8'h03);
      rd_chk(8'h21, 8'h03);
      arrs_host_model_i.restore();
      @(negedge mclk);
      `CHK(restore_busy, 1'b1)
      `CHK(safety_timer_rst, 1'b1)
      @(posedge mclk);
      for (logic [7:0] a = 8'h20; a < 8'h24; a++) rd_chk(a, 8'h00);
      `CHK(restore_busy, 1'b0)
      `CHK(safety_timer_rst, 1'b0)
      finish_test();
   end
   initial begin
      repeat (4000) @(posedge mclk);
      num_errors++;
      finish_test();
   end
endmodule
bind arrs_top arrs_top_chk arrs_top_chk_i (.mclk, .arst_n, .reg_addr, .reg_rd, .reg_wr,
   .reg_rdata, .reg_hit, .restore_req, .watchdog_expired, .restore_busy, .safety_timer_rst,
   .top_cell_voltage_valid, .top_cell_voltage_result, .thermistor_ratio_valid,
   .die_temperature_valid);
